/* File: rtl/cch_pkg.sv */
// Constants for the host-side controller of a 16-bit command/data CAM port.
// Assumes one 100 MHz clock; pin timing counts derive from the figures below.
`default_nettype none
package cch_pkg;

  // Clock and pin timing, in ns as figures and derived cycle counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS    = 2;   // Control valid before chip enable low
  localparam int T_LOW_NS      = 75;  // Shortest chip enable low width
  localparam int T_HIGH_NS     = 15;  // Chip enable high width
  localparam int SYNC_STAGES   = 2;   // Input synchroniser depth on the data pins
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC       = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int HIGH_CYC      = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;

  // Software register offsets (word indices on the local port)
  localparam logic [3:0] OFS_OP       = 4'h0;
  localparam logic [3:0] OFS_TX_WORD  = 4'h1;
  localparam logic [3:0] OFS_CTRL     = 4'h2;
  localparam logic [3:0] OFS_SEG      = 4'h3;
  localparam logic [3:0] OFS_RX_WORD  = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam logic [3:0] OFS_NEXTFREE = 4'h6;
  localparam logic [3:0] OFS_IDENTITY = 4'h7;

  // Operation codes written to the operation register
  localparam logic [3:0] OP_NONE     = 4'h0;
  localparam logic [3:0] OP_CMD_WR   = 4'h1;  // One command write of the tx word
  localparam logic [3:0] OP_CMD_RD   = 4'h2;  // One command read
  localparam logic [3:0] OP_SEL_RD   = 4'h3;  // Select instruction then command read
  localparam logic [3:0] OP_STAT_RD  = 4'h4;  // Two back-to-back command reads
  localparam logic [3:0] OP_CTRL_WR  = 4'h5;  // Select instruction then control word
  localparam logic [3:0] OP_SEG_WR   = 4'h6;  // Select instruction then segment word
  localparam logic [3:0] OP_DATA_WR  = 4'h7;  // One data write of the tx word
  localparam logic [3:0] OP_DATA_RD  = 4'h8;  // One data read

  // Device control word fields
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_MATCH_LO  = 13;
  localparam int CTL_FULL_LO   = 11;
  localparam int CTL_XLAT_LO   = 9;
  localparam int CTL_SPLIT_LO  = 6;
  localparam int CTL_MASK_LO   = 4;
  localparam int CTL_STEP_LO   = 2;
  localparam int CTL_MODE_LO   = 0;
  localparam logic [1:0] CODE2_RESERVED = 2'h2;
  localparam logic [1:0] CODE2_KEEP     = 2'h3;
  localparam logic [15:0] CTL_RESET_VAL = 16'hFFFF;  // All fields keep, no reset

  // Segment control strobe positions (active low loads)
  localparam int SEG_DEST_LIMIT_LD = 15;
  localparam int SEG_SRC_LIMIT_LD  = 10;
  localparam int SEG_DEST_COUNT_LD = 5;
  localparam int SEG_SRC_COUNT_LD  = 2;
  localparam logic [15:0] SEG_RESET_VAL = 16'hFFFF;  // All loads idle

  // Status and identity word fields
  localparam int ST_FULL_N_BIT  = 31;
  localparam int ST_MULTI_N_BIT = 30;
  localparam int ST_VALID_LO    = 28;
  localparam int ST_HIT_N_BIT   = 0;
  localparam int ID_LO          = 4;

  // Host controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_LOW   = 4'b0100,
    ST_HIGH  = 4'b1000
  } cch_state_type;

endpackage

`default_nettype wire

/* File: rtl/cch_host.sv */
// Host-side controller that drives a 64-bit-word CAM over its 16-bit
// command/data pins with chip-enable framed cycles.
// Assumes a 100 MHz clock, a single-cycle local register port, and a device
// that needs no clock of its own.
//
// Design decisions made here: the address-and-strobe port and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module cch_host
  import cch_pkg::*;
#(
  parameter int DEPTH_BITS = 13  // Address bits of one device: 10, 11, 12 or 13
) (
  input  wire logic        clk,        // System clock
  input  wire logic        rst_n,      // Asynchronous reset, active low
  input  wire logic [3:0]  reg_addr,   // Local register index
  input  wire logic [31:0] reg_wdata,  // Local write data
  input  wire logic        reg_wr,     // Local write strobe
  input  wire logic        reg_rd,     // Local read strobe
  output logic      [31:0] reg_rdata,  // Local read data, cycle after strobe
  output logic             cam_e_n,    // Chip enable to device, active low
  output logic             cam_cm_n,   // Low selects command cycle, high data
  output logic             cam_w_n,    // Low selects write, high read
  input  wire logic [15:0] dq_in,      // Data pins as seen from the device
  output logic      [15:0] dq_out,     // Data driven onto the pins
  output logic             dq_oe,      // High while the host drives the pins
  output logic             busy        // High while an operation runs
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Reserved two-bit codes collapse to keep
  function automatic logic [1:0] clean2(input logic [1:0] code);
    clean2 = (code == CODE2_RESERVED) ? CODE2_KEEP : code;
  endfunction

  // Number of device cycles an operation takes
  function automatic logic [1:0] op_len(input logic [3:0] op);
    case (op)
      OP_SEL_RD, OP_STAT_RD, OP_CTRL_WR, OP_SEG_WR: op_len = 2'd2;
      OP_CMD_WR, OP_CMD_RD, OP_DATA_WR, OP_DATA_RD: op_len = 2'd1;
      default:                                      op_len = 2'd0;
    endcase
  endfunction

  // Whether a given step of an operation is a write cycle
  // Select-then-read writes its select word first and reads second
  function automatic logic step_write(input logic [3:0] op, input logic step);
    case (op)
      OP_CMD_WR, OP_DATA_WR, OP_CTRL_WR, OP_SEG_WR: step_write = 1'b1;
      OP_SEL_RD:                                    step_write = ~step;
      default:                                      step_write = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and synchroniser

  cch_state_type            state;
  cch_state_type            next_state;
  logic [CNT_W-1:0]         cnt;
  logic [CNT_W-1:0]         next_cnt;
  logic [3:0]               op;
  logic                     step;
  logic [15:0]              tx_word;
  logic [15:0]              ctrl_word;
  logic [15:0]              seg_word;
  logic [31:0]              rx_word;
  logic [15:0]              dq_meta;
  logic [15:0]              dq_sync;

  // Two-stage synchroniser on the data pins
  // Only the second stage feeds logic; the first may still be settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local port decode

  wire        wr_op    = reg_wr && (reg_addr == OFS_OP);
  wire        launch   = wr_op && (state == ST_IDLE) && (op_len(reg_wdata[3:0]) != 2'd0);
  wire        last_step = (op_len(op) == 2'd1) || step;
  wire        cur_write = step_write(op, step);
  wire        cnt_zero  = (cnt == '0);

  // Operation and step that the coming device cycle will run; a launch
  // takes its code straight from the write data, a second step from op
  wire [3:0]  next_op       = launch ? reg_wdata[3:0] : op;
  wire        next_step_sel = launch ? 1'b0 : (state == ST_HIGH) ? 1'b1 : step;
  wire        next_write    = step_write(next_op, next_step_sel);
  wire        next_cmd      = (next_op != OP_DATA_WR) && (next_op != OP_DATA_RD);

  // Control word with reserved codes replaced, reset bit passed as given
  wire [15:0] ctrl_clean = {ctrl_word[CTL_RESET_BIT],
                            clean2(ctrl_word[CTL_MATCH_LO +: 2]),
                            clean2(ctrl_word[CTL_FULL_LO +: 2]),
                            clean2(ctrl_word[CTL_XLAT_LO +: 2]),
                            ctrl_word[CTL_SPLIT_LO +: 3],
                            ctrl_word[CTL_MASK_LO +: 2],
                            ctrl_word[CTL_STEP_LO +: 2],
                            clean2(ctrl_word[CTL_MODE_LO +: 2])};

  // Word for a write step: select instruction first, then the payload
  wire [15:0] step_word = (!next_step_sel)       ? tx_word :
                          (op == OP_CTRL_WR)     ? ctrl_clean :
                          (op == OP_SEG_WR)      ? seg_word : tx_word;

  // Local copies that software writes
  // Held here; they reach the pins only when an operation runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word   <= 16'h0000;
      ctrl_word <= CTL_RESET_VAL;
      seg_word  <= SEG_RESET_VAL;
    end else if (reg_wr) begin
      if (reg_addr == OFS_TX_WORD) tx_word   <= reg_wdata[15:0];
      if (reg_addr == OFS_CTRL)    ctrl_word <= reg_wdata[15:0];
      if (reg_addr == OFS_SEG)     seg_word  <= reg_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin cycle sequencer

  // Next state and counter
  // One device cycle: setup, enable low for LOW_CYC, then high for HIGH_CYC
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_SETUP;
          next_cnt   = CNT_W'(SETUP_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          next_state = ST_LOW;
          next_cnt   = CNT_W'(LOW_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_LOW: begin
        if (cnt_zero) begin
          next_state = ST_HIGH;
          next_cnt   = CNT_W'(HIGH_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_HIGH: begin
        if (!cnt_zero) begin
          next_cnt = cnt - 1'b1;
        end else if (last_step) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_SETUP;
          next_cnt   = CNT_W'(SETUP_CYC - 1);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // State, operation and step registers
  // Step moves on only where a high phase leads into a second cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= '0;
      op    <= OP_NONE;
      step  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (launch) begin
        op   <= reg_wdata[3:0];
        step <= 1'b0;
      end else if (state == ST_HIGH && cnt_zero && !last_step) begin
        step <= 1'b1;
      end
    end
  end

  // Pin outputs, set up one cycle ahead of chip enable low
  // Loading them on entry to setup keeps them clear of the falling enable
  wire next_e_n  = !(next_state == ST_LOW);
  wire next_oe   = ((next_state == ST_SETUP) || (next_state == ST_LOW)) && next_write;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cam_e_n  <= 1'b1;
      cam_cm_n <= 1'b1;
      cam_w_n  <= 1'b1;
      dq_out   <= 16'h0000;
      dq_oe    <= 1'b0;
    end else begin
      cam_e_n <= next_e_n;
      dq_oe   <= next_oe;
      if (next_state == ST_SETUP) begin
        cam_cm_n <= !next_cmd;
        cam_w_n  <= !next_write;
        dq_out   <= step_word;
      end else if (next_state == ST_IDLE) begin
        cam_cm_n <= 1'b1;
        cam_w_n  <= 1'b1;
      end
    end
  end

  // Read capture: first read fills the low half, second the high half
  // Sampled in the last low cycle, when the synchronised pins have settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word <= 32'h0000_0000;
    end else if (state == ST_LOW && cnt_zero && !cur_write) begin
      if (op == OP_STAT_RD && step) rx_word[31:16] <= dq_sync;
      else                          rx_word[15:0]  <= dq_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of words read back

  wire [15:0] free_index_mask = 16'((32'h1 << DEPTH_BITS) - 1);
  wire [15:0] vacant_location   = rx_word[15:0] & free_index_mask;
  wire [15:0] cascade_chip_bits = rx_word[15:0] & ~free_index_mask;

  wire [15:0] hit_mask      = 16'(((32'h1 << DEPTH_BITS) - 1) << 1);
  wire [15:0] hit_location  = (rx_word[15:0] & hit_mask) >> 1;
  wire        hit_n         = rx_word[ST_HIT_N_BIT];
  wire        cam_full_n    = rx_word[ST_FULL_N_BIT];
  wire        multi_hit_n   = rx_word[ST_MULTI_N_BIT];
  wire [1:0]  entry_validity_code = rx_word[ST_VALID_LO +: 2];
  wire [11:0] high_page     = (DEPTH_BITS == 10) ? {1'b0, rx_word[26:16]}
                                                 : rx_word[27:16];

  wire [11:0] dev_identity = rx_word[15:ID_LO];
  wire [3:0]  persistent_source_setting = rx_word[ID_LO-1:0];

  // Segment word shown with strobe positions cleared, as the device returns it
  wire [15:0] seg_view = seg_word & ~(16'h0001 << SEG_DEST_LIMIT_LD) & ~(16'h0001 << SEG_SRC_LIMIT_LD) &
                         ~(16'h0001 << SEG_DEST_COUNT_LD) & ~(16'h0001 << SEG_SRC_COUNT_LD);
  wire [15:0] ctrl_view = ctrl_clean & ~(16'h0001 << CTL_RESET_BIT);

  // Read mux
  // Decoded views place the page bits by DEPTH_BITS
  wire [31:0] rd_mux =
    (reg_addr == OFS_OP)       ? {27'h0, busy, op} :
    (reg_addr == OFS_TX_WORD)  ? {16'h0000, tx_word} :
    (reg_addr == OFS_CTRL)     ? {16'h0000, ctrl_view} :
    (reg_addr == OFS_SEG)      ? {16'h0000, seg_view} :
    (reg_addr == OFS_RX_WORD)  ? rx_word :
    (reg_addr == OFS_STATUS)   ? {cam_full_n, multi_hit_n, entry_validity_code, high_page,
                                  hit_location[14:0], hit_n} :
    (reg_addr == OFS_NEXTFREE) ? {cascade_chip_bits, vacant_location} :
    (reg_addr == OFS_IDENTITY) ? {16'h0000, dev_identity, persistent_source_setting} :
                                 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // Busy straight from the state; a launch while busy is dropped
  assign busy = (state != ST_IDLE);

endmodule

`default_nettype wire

/* File: bench/cch_tb_pkg.sv */
// Bench constants and device register update helpers.
// Assumes nothing beyond the bench files that import it.
`default_nettype none
package cch_tb_pkg;
  // Select instruction words; values are arbitrary
  localparam logic [15:0] SEL_CT = 16'h0A01;
  localparam logic [15:0] SEL_SC = 16'h0A02;
  localparam logic [15:0] SEL_NF = 16'h0A03;
  localparam logic [15:0] SEL_PS = 16'h0A04;
  localparam logic [11:0] DEV_ID = 12'h5C3;  // Arbitrary identity code
  // Control update: keep codes hold a field, reserved codes only in the fields at bits 13, 11, 9 and 0
  function automatic logic [15:0] ctl_merge(input logic [15:0] o, input logic [15:0] w);
    int lo[6] = '{13, 11, 9, 4, 2, 0};
    ctl_merge = o;
    foreach (lo[i]) begin
      if (w[lo[i]+:2] != 2'h3 && !(w[lo[i]+:2] == 2'h2 && (lo[i] > 8 || lo[i] == 0)))
        ctl_merge[lo[i]+:2] = w[lo[i]+:2];
    end
    if (w[8:6] != 3'h7) ctl_merge[8:6] = w[8:6];
    ctl_merge[15] = 1'b0;
  endfunction
  // Segment update: low strobes load their fields, strobes read as 0
  function automatic logic [15:0] seg_merge(input logic [15:0] o, input logic [15:0] w);
    seg_merge = o;
    if (!w[15]) seg_merge[14:11] = w[14:11];
    if (!w[10]) seg_merge[9:6] = w[9:6];
    if (!w[5]) seg_merge[4:3] = w[4:3];
    if (!w[2]) seg_merge[1:0] = w[1:0];
    seg_merge &= 16'h7BDB;
  endfunction
endpackage
`default_nettype wire

/* File: bench/cch_dev_model.sv */
// Behavioural CAM device on the 16-bit command/data pins.
// Assumes the bench resolves the data pins and feeds the status values.
`timescale 1ns/1ps
`default_nettype none
module cch_dev_model import cch_tb_pkg::*; #(
  parameter int RD_DELAY_NS = 20  // Read access time
) (
  input  wire logic        cam_e_n,   // Chip enable
  input  wire logic        cam_cm_n,  // Command or data
  input  wire logic        cam_w_n,   // Write or read
  input  wire logic [15:0] dq,        // Resolved data pins
  input  wire logic [31:0] stat,      // Status to report
  input  wire logic [15:0] nf,        // Next free word
  input  wire logic [3:0]  ps,        // Persistent source
  output logic      [15:0] dq_dev     // Device drive
);
  logic [15:0] ctrl = 16'h0, seg = 16'h0, sel = 16'h0, d;
  logic        hi = 1'b0, cm, rw;
  initial dq_dev = 16'hA5A5;
  // One framed cycle: decode mid-low, update at the rising enable
  always begin
    @(negedge cam_e_n);
    #RD_DELAY_NS;
    cm = cam_cm_n;
    rw = cam_w_n;
    d = dq;
    if (rw) dq_dev = sel == SEL_CT ? {1'b0, ctrl[14:0]} : sel == SEL_SC ? seg :
                     sel == SEL_NF ? nf : sel == SEL_PS ? {DEV_ID, ps} :
                     hi ? stat[31:16] : stat[15:0];
    @(posedge cam_e_n);
    if (rw) begin
      hi = !cm && !hi && sel == 16'h0;
      sel = 16'h0;
    end else begin
      if (sel == SEL_CT) ctrl = d[15] ? ctl_merge(ctrl, d) : 16'h0;
      if (sel == SEL_SC) seg = seg_merge(seg, d);
      sel = (!cm && sel != SEL_CT && sel != SEL_SC) ? d : 16'h0;
      hi = 1'b0;
    end
    dq_dev = ~dq_dev;  // Released pins show no stale value
  end
endmodule
`default_nettype wire

/* File: bench/cch_host_checker.sv */
// Pin and register port assertions for the host controller.
// Assumes binding to the controller top with its own ports.
`timescale 1ns/1ps
`default_nettype none
module cch_host_checker import cch_pkg::*; #(
  parameter int DEPTH_BITS = 13  // Device depth bits
) (
  input wire logic        clk,        // Clock
  input wire logic        rst_n,      // Reset
  input wire logic [3:0]  reg_addr,   // Index
  input wire logic [31:0] reg_wdata,  // Write data
  input wire logic        reg_wr,     // Write strobe
  input wire logic        reg_rd,     // Read strobe
  input wire logic [31:0] reg_rdata,  // Read data
  input wire logic        cam_e_n,    // Enable
  input wire logic        cam_cm_n,   // Command
  input wire logic        cam_w_n,    // Write
  input wire logic [15:0] dq_in,      // Pins
  input wire logic [15:0] dq_out,     // Drive
  input wire logic        dq_oe,      // Drive enable
  input wire logic        busy        // Busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Launch and cycle kind decodes
  wire op_go  = reg_wr && reg_addr == OFS_OP && !busy;
  wire cmd_rd = !cam_cm_n && cam_w_n;
  wire cmd_wr = !cam_cm_n && !cam_w_n;
  chk_low_ten: assert property ($fell(cam_e_n) |-> (!cam_e_n)[*8] ##1 (!cam_e_n)[*2] ##1 cam_e_n)
    else $error("enable low width wrong");
  chk_pins_hold: assert property (!cam_e_n && !$past(cam_e_n) |-> $stable({cam_cm_n, cam_w_n, dq_out, dq_oe}))
    else $error("pins moved during enable low");
  chk_high_gap: assert property ($rose(cam_e_n) |-> cam_e_n[*2]) else $error("enable high too short");
  chk_no_fight: assert property (!cam_e_n && cam_w_n |-> !dq_oe) else $error("host drives on a read");
  chk_write_drive: assert property (!cam_e_n && !cam_w_n |-> dq_oe) else $error("host idle on a write");
  chk_idle_quiet: assert property (!busy |-> cam_e_n) else $error("enable low while idle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > OFS_IDENTITY |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_status_pair: assert property (op_go && reg_wdata[3:0] == OP_STAT_RD |->
    ##[1:3] ($fell(cam_e_n) && cmd_rd) ##13 ($fell(cam_e_n) && cmd_rd)) else $error("status reads not paired");
  chk_select_read: assert property (op_go && reg_wdata[3:0] == OP_SEL_RD |->
    ##[1:3] ($fell(cam_e_n) && cmd_wr) ##13 ($fell(cam_e_n) && cmd_rd)) else $error("select not followed by read");
  chk_ctrl_clean: assert property (op_go && reg_wdata[3:0] == OP_CTRL_WR |->
    ##[1:3] ($fell(cam_e_n) && cmd_wr) ##13 ($fell(cam_e_n) && !cam_w_n && dq_out[14:13] != CODE2_RESERVED
    && dq_out[12:11] != CODE2_RESERVED && dq_out[10:9] != CODE2_RESERVED && dq_out[1:0] != CODE2_RESERVED))
    else $error("reserved control code sent");
endmodule
`default_nettype wire

/* File: bench/cch_host_tb.sv */
// Self-checking bench for the host controller against a device model.
// Assumes the bench package, device model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cch_host_tb import cch_pkg::*, cch_tb_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cam_e_n, cam_cm_n, cam_w_n, dq_oe, busy;
  logic [3:0]  reg_addr = 4'h0, ps = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, stat = 32'h0, rdv;
  logic [15:0] dq_out, dq_dev, nf = 16'h0, ectl = 16'h0, eseg = 16'h0, w;
  integer      num_errors = 0, comparisons = 0, seed = 32'h088CF75C, cycles = 0;
  wire  [15:0] dq_in = dq_oe ? dq_out : dq_dev;
  always #5 clk = ~clk;
  cch_host u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                  .cam_e_n, .cam_cm_n, .cam_w_n, .dq_in, .dq_out, .dq_oe, .busy);
  cch_dev_model u_dev (.cam_e_n, .cam_cm_n, .cam_w_n, .dq(dq_in), .stat, .nf, .ps, .dq_dev);
  ////////////////////////////////////////////////////////////////////////
  // Compare, register access and operation tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask
  task automatic op(input logic [3:0] o, input logic [15:0] tx);
    int i;
    wr(OFS_TX_WORD, {16'h0, tx});
    wr(OFS_OP, {28'h0, o});
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) break;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl reset", {16'h0, CTL_RESET_VAL & 16'h7FFF}, rdv);
    rd(OFS_SEG);
    chk("seg reset", {16'h0, SEG_RESET_VAL & 16'h7BDB}, rdv);
    rd(4'hC);
    chk("unmapped", 32'h0, rdv);
    for (int i = 0; i < 16; i++) begin
      w = i < 8 ? {1'b1, {3{i[1:0]}}, i[2:0], {3{i[1:0]}}} : 16'($random(seed)) | 16'h8000;
      if (i == 12) w[15] = 1'b0;
      wr(OFS_CTRL, {16'h0, w});
      op(OP_CTRL_WR, SEL_CT);
      ectl = w[15] ? ctl_merge(ectl, w) : 16'h0;
      op(OP_SEL_RD, SEL_CT);
      rd(OFS_RX_WORD);
      chk("control", {16'h0, ectl}, {16'h0, rdv[15:0]});
    end
    for (int i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      wr(OFS_SEG, {16'h0, w});
      op(OP_SEG_WR, SEL_SC);
      eseg = seg_merge(eseg, w);
      op(OP_SEL_RD, SEL_SC);
      rd(OFS_RX_WORD);
      chk("segment", {16'h0, eseg}, {16'h0, rdv[15:0]});
    end
    for (int i = 0; i < 4; i++) begin
      stat = $random(seed);
      nf = 16'($random(seed));
      ps = 4'($random(seed));
      op(OP_STAT_RD, 16'h0);
      rd(OFS_RX_WORD);
      chk("status", stat, rdv);
      rd(OFS_STATUS);
      chk("status view", {stat[31:16], 2'b00, stat[13:1], stat[0]}, rdv);
      rd(OFS_OP);
      chk("op readback", {28'h0, OP_STAT_RD}, rdv);
      op(OP_CMD_WR, SEL_NF);
      op(OP_DATA_WR, ~nf);
      op(OP_SEL_RD, SEL_NF);
      rd(OFS_RX_WORD);
      chk("next free", {16'h0, nf}, {16'h0, rdv[15:0]});
      rd(OFS_NEXTFREE);
      chk("free split", {nf[15:13], 13'h0000, 3'h0, nf[12:0]}, rdv);
      op(OP_SEL_RD, SEL_PS);
      rd(OFS_RX_WORD);
      chk("identity", {16'h0, DEV_ID, ps}, {16'h0, rdv[15:0]});
      rd(OFS_IDENTITY);
      chk("identity view", {16'h0, DEV_ID, ps}, rdv);
      op(OP_DATA_RD, 16'h0);
      op(OP_CMD_RD, 16'h0);
      rd(OFS_RX_WORD);
      chk("status low", {16'h0, stat[15:0]}, {16'h0, rdv[15:0]});
      op(OP_CMD_RD, 16'h0);
      rd(OFS_RX_WORD);
      chk("status high", {16'h0, stat[31:16]}, {16'h0, rdv[15:0]});
    end
    summarize();
  end
endmodule
// Checker attached to every controller instance
bind cch_host cch_host_checker #(.DEPTH_BITS(DEPTH_BITS)) u_chk (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cam_e_n, .cam_cm_n, .cam_w_n, .dq_in, .dq_out, .dq_oe, .busy);
`default_nettype wire
